//--- include/autoreload_timer_pkg.sv
// Constants, register map and carrier types of the auto-reload timer.
// Functional notes
// - Set/reset wave mode: zero match drives polarity level, compare match the opposite.
// - Toggle wave mode inverts the wave pin on every masked compare match.
// - Wrap set mode: pin sets on zero overflow, releases when wrap flag cleared.
// - Wrap toggle mode inverts the wrap pin on every zero overflow.
// - With reload enabled, captures never write the reload/capture register.
// - Source A restart: input A edge reloads counter, sets A flag, counts down.
// - Input A event while A flag set sets A overrun with the reload.
// - Input B edge captures counter and sets B flag; repeat sets overrun instead.
// - Both B flags must be cleared before another input B capture.
// - Coincident B capture and A reload: capture old count, then reload.
// - Source B restart: B event captures if flags clear, then always reloads.
// - In source B restart mode, input A only sets its flags.
// - Source B mode from reset: first B event captures zero, then restarts.
// - Software restart mode: run enable reloads and starts; B only captures.
// - Reload cleared: counter free-runs from all ones; captures leave pins alone.
// - Free-run: capture targets fed by B and A, each with own edge select.
// - Free-run: A edge with flags clear captures into reload register, else overrun.
// - Interrupt is OR of five flag-and-enable terms.
// - Flags latch regardless of enables; late enable raises interrupt at once.
// - Masked compare and masked zero comparisons through the mask register.
// - Zero overflow reloads all ones or reload register, and sets wrap flag.
// - Run enable cleared holds counter at zero; setting it arms inputs and, outside source A/B restart, starts.
// - Prescaler divides the clock by 1, 4 or 16, or stops it.
package autoreload_timer_pkg;
    localparam int CNT_W = 16;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FLAGS = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_COMPARE = 8'h0c;
    localparam logic [7:0] OFS_MASK = 8'h10;
    localparam logic [7:0] OFS_RELOAD_CAPTURE = 8'h14;
    localparam logic [7:0] OFS_CAPTURE = 8'h18;
    localparam logic [7:0] OFS_COUNTER = 8'h1c;
    localparam logic [15:0] ALL_ONES = 16'hffff;
    localparam logic [15:0] ZERO_COUNT = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'hffff;
    localparam logic [1:0] PSC_OFF = 2'h0;
    localparam logic [1:0] PSC_DIV1 = 2'h1;
    localparam logic [1:0] PSC_DIV4 = 2'h2;
    localparam logic [3:0] DIV4_LAST = 4'h3;
    localparam logic [3:0] DIV16_LAST = 4'hf;
    localparam logic [1:0] SRC_RUN = 2'h0;
    localparam logic [1:0] SRC_A = 2'h1;
    localparam logic [1:0] SRC_B = 2'h2;
    localparam logic [1:0] SRC_NONE = 2'h3;
    // Control word, bit 11 down to bit 0.
    typedef struct packed {
        logic input_b_edge_sel;
        logic input_a_edge_sel;
        logic reload_source_hi;
        logic reload_source_lo;
        logic wave_polarity;
        logic wave_toggle_select;
        logic wave_out_enable;
        logic wrap_out_toggle_select;
        logic run_enable;
        logic reload_enable;
        logic [1:0] prescale;
    } ctrl_t;
    // Event flags, bit 6 down to bit 0.
    typedef struct packed {
        logic zero_match_flag;
        logic match_flag;
        logic wrap_flag;
        logic input_b_overrun;
        logic input_b_flag;
        logic input_a_overrun;
        logic input_a_flag;
    } flags_t;
    // Interrupt enables, bit 4 down to bit 0.
    typedef struct packed {
        logic zero_irq_en;
        logic match_irq_en;
        logic wrap_irq_en;
        logic input_b_irq_en;
        logic input_a_irq_en;
    } irq_en_t;
    localparam ctrl_t CTRL_RESET = 12'h000;
    localparam flags_t FLAGS_RESET = 7'h00;
    localparam irq_en_t IRQ_EN_RESET = 5'h00;
    typedef enum logic {ST_HOLD = 1'b0, ST_COUNT = 1'b1} count_state_t;
endpackage

//--- rtl/autoreload_timer_wave_capture.sv
// Auto-reload down-counter with wave outputs, captures and APB registers.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module autoreload_timer_wave_capture
    import autoreload_timer_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input wire logic mclk,           // System clock, 125 MHz.
    input wire logic resetn,         // Synchronous reset, active low.
    input wire logic psel,           // APB select.
    input wire logic penable,        // APB access phase.
    input wire logic pwrite,         // APB direction, high for write.
    input wire logic [7:0] paddr,    // APB byte address.
    input wire logic [31:0] pwdata,  // APB write data.
    output logic [31:0] prdata,      // APB read data.
    output logic pready,             // APB ready.
    output logic pslverr,            // APB error on unmapped address.
    input wire logic input_a,        // Capture/restart input A, asynchronous.
    input wire logic input_b,        // Capture/restart input B, asynchronous.
    output logic wave_out_pin,       // Compare-driven waveform pin.
    output logic wrap_out_pin,       // Overflow-driven pin.
    output logic irq                 // Interrupt to the core, active high.
);
    // The comparators and capture paths are built for exactly 16 bits.
    if (CW != 16) begin : g_bad_width
        $error("counter width must be 16");
    end

    ctrl_t ctrl;
    flags_t flags;
    irq_en_t irq_en;
    count_state_t state;
    logic [15:0] compare_reg;
    logic [15:0] mask_reg;
    logic [15:0] reload_capture_reg;
    logic [15:0] capture_reg;
    logic [15:0] counter_value;
    logic [3:0] div_count;
    logic run_q;
    logic a_meta, a_sync, a_prev;
    logic b_meta, b_sync, b_prev;

    // Bus decode; writes land at the access edge where pready is high.
    wire logic setup_ph = psel & ~penable;
    wire logic wr_en = psel & penable & pready & pwrite;
    wire logic wr_ctrl = wr_en & (paddr == OFS_CTRL);
    wire logic wr_flags = wr_en & (paddr == OFS_FLAGS);
    wire logic wr_irq_en = wr_en & (paddr == OFS_IRQ_EN);
    wire logic wr_compare = wr_en & (paddr == OFS_COMPARE);
    wire logic wr_mask = wr_en & (paddr == OFS_MASK);
    wire logic wr_rlc = wr_en & (paddr == OFS_RELOAD_CAPTURE);
    wire logic mapped = (paddr == OFS_CTRL) | (paddr == OFS_FLAGS)
        | (paddr == OFS_IRQ_EN) | (paddr == OFS_COMPARE)
        | (paddr == OFS_MASK) | (paddr == OFS_RELOAD_CAPTURE)
        | (paddr == OFS_CAPTURE) | (paddr == OFS_COUNTER);
    wire logic [31:0] rd_mux =
        (paddr == OFS_CTRL) ? {20'h00000, ctrl} :
        (paddr == OFS_FLAGS) ? {25'h0000000, flags} :
        (paddr == OFS_IRQ_EN) ? {27'h0000000, irq_en} :
        (paddr == OFS_COMPARE) ? {16'h0000, compare_reg} :
        (paddr == OFS_MASK) ? {16'h0000, mask_reg} :
        (paddr == OFS_RELOAD_CAPTURE) ? {16'h0000, reload_capture_reg} :
        (paddr == OFS_CAPTURE) ? {16'h0000, capture_reg} :
        (paddr == OFS_COUNTER) ? {16'h0000, counter_value} : 32'h00000000;

    // Prescaler tick; the divider restarts whenever the timer is stopped.
    wire logic run = ctrl.run_enable;
    wire logic psc_on = run & (ctrl.prescale != PSC_OFF);
    wire logic tick = psc_on & ((ctrl.prescale == PSC_DIV1)
        | ((ctrl.prescale == PSC_DIV4) & (div_count[1:0] == DIV4_LAST[1:0]))
        | (div_count == DIV16_LAST));

    // Edge detection reads only the second and third synchroniser stages.
    wire logic a_edge = run & (ctrl.input_a_edge_sel ? (a_sync & ~a_prev)
        : (~a_sync & a_prev));
    wire logic b_edge = run & (ctrl.input_b_edge_sel ? (b_sync & ~b_prev)
        : (~b_sync & b_prev));

    // Restart sources; outside reload mode none of them touch the count.
    wire logic [1:0] src = {ctrl.reload_source_hi, ctrl.reload_source_lo};
    wire logic reload_a = ctrl.reload_enable & (src == SRC_A)
        & a_edge;
    wire logic reload_b = ctrl.reload_enable & (src == SRC_B)
        & b_edge;
    wire logic reload_sw = ctrl.reload_enable & (src == SRC_RUN)
        & run & ~run_q;
    wire logic restart = reload_a | reload_b | reload_sw;
    wire logic auto_start = run & (~ctrl.reload_enable | (src == SRC_NONE));
    wire logic counting = (state == ST_COUNT);

    // Masked comparisons and the events that they raise on a count tick.
    wire logic [15:0] masked_cnt = counter_value & mask_reg;
    wire logic masked_match = masked_cnt == (compare_reg & mask_reg);
    wire logic zero_hit = masked_cnt == ZERO_COUNT;
    wire logic match_ev = counting & tick & masked_match;
    wire logic zero_ev = counting & tick & zero_hit;
    wire logic zero_wrap = counting & tick & (counter_value == ZERO_COUNT);

    // Capture qualification; a set overrun locks the input out.
    wire logic a_free = ~flags.input_a_flag & ~flags.input_a_overrun;
    wire logic b_free = ~flags.input_b_flag & ~flags.input_b_overrun;
    wire logic cap_a = ~ctrl.reload_enable & a_edge & a_free;
    wire logic cap_b = b_edge & b_free;

    // Flags: hardware set wins over a software clear in the same cycle.
    wire flags_t flag_set = {zero_ev, match_ev, zero_wrap,
        b_edge & flags.input_b_flag, cap_b,
        a_edge & flags.input_a_flag, a_edge & a_free};
    wire flags_t flag_clr = wr_flags ? ~pwdata[6:0] : 7'h00;
    wire flags_t next_flags = (flags & ~flag_clr) | flag_set;
    wire irq_en_t irq_terms = {flags.zero_match_flag, flags.match_flag,
        flags.wrap_flag, flags.input_b_flag, flags.input_a_flag} & irq_en;

    // Counter; a restart wins over the wrap, and stopping clears it.
    wire logic [15:0] wrap_value = ctrl.reload_enable ? reload_capture_reg
        : ALL_ONES;
    wire logic [15:0] next_counter =
        ~run ? ZERO_COUNT :
        restart ? reload_capture_reg :
        zero_wrap ? wrap_value :
        (counting & tick) ? counter_value - 16'h0001 : counter_value;

    // Wave pin; in set/reset mode a compare match beats a zero match.
    wire logic next_wave =
        ~ctrl.wave_out_enable ? ctrl.wave_polarity :
        ctrl.wave_toggle_select ? (wave_out_pin ^ match_ev) :
        match_ev ? ~ctrl.wave_polarity :
        zero_ev ? ctrl.wave_polarity : wave_out_pin;

    // Wrap pin; set mode follows the flag, so clearing the flag releases it.
    wire logic next_wrap_pin =
        ctrl.wrap_out_toggle_select ? (wrap_out_pin ^ zero_wrap) :
        zero_wrap ? 1'b1 : (wrap_out_pin & flags.wrap_flag);

    // Count state: a restart mode waits at zero for its trigger.
    count_state_t next_state;
    always_comb begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                if (restart | auto_start) begin
                    next_state = ST_COUNT;
                end
            end
            ST_COUNT: begin
                next_state = ST_COUNT;
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
        if (~run) begin
            next_state = ST_HOLD;
        end
    end

    // Input synchronisers; the first stage feeds only the second.
    always_ff @(posedge mclk) begin
        a_meta <= input_a;
        a_sync <= a_meta;
        a_prev <= a_sync;
        b_meta <= input_b;
        b_sync <= b_meta;
        b_prev <= b_sync;
    end

    // Bus answer is registered in the setup cycle: one wait-free access.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~mapped;
            if (setup_ph) begin
                prdata <= rd_mux;
            end
        end
    end

    // Software-owned registers.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ctrl <= CTRL_RESET;
            irq_en <= IRQ_EN_RESET;
            compare_reg <= ZERO_COUNT;
            mask_reg <= MASK_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= pwdata[11:0];
            end
            if (wr_irq_en) begin
                irq_en <= pwdata[4:0];
            end
            if (wr_compare) begin
                compare_reg <= pwdata[15:0];
            end
            if (wr_mask) begin
                mask_reg <= pwdata[15:0];
            end
        end
    end

    // Reload/capture register is read-only while it serves as a capture.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            reload_capture_reg <= ZERO_COUNT;
            capture_reg <= ZERO_COUNT;
        end else begin
            if (cap_a) begin
                reload_capture_reg <= counter_value;
            end else if (wr_rlc & ctrl.reload_enable) begin
                reload_capture_reg <= pwdata[15:0];
            end
            if (cap_b) begin
                capture_reg <= counter_value;
            end
        end
    end

    // Counter, prescaler, state, flags, pins and interrupt.
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            counter_value <= ZERO_COUNT;
            div_count <= 4'h0;
            run_q <= 1'b0;
            state <= ST_HOLD;
            flags <= FLAGS_RESET;
            wave_out_pin <= 1'b0;
            wrap_out_pin <= 1'b0;
            irq <= 1'b0;
        end else begin
            counter_value <= next_counter;
            div_count <= psc_on ? div_count + 4'h1 : 4'h0;
            run_q <= run;
            state <= next_state;
            flags <= next_flags;
            wave_out_pin <= next_wave;
            wrap_out_pin <= next_wrap_pin;
            irq <= |irq_terms;
        end
    end

    // Properties on the pins, captures and counter.
    chk_wave_disabled: assert property (@(posedge mclk) disable iff (!resetn)
        !ctrl.wave_out_enable |=> wave_out_pin == $past(ctrl.wave_polarity))
        else $error("wave pin not at polarity while disabled");
    chk_wave_toggle: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl.wave_out_enable && ctrl.wave_toggle_select && match_ev
        |=> wave_out_pin != $past(wave_out_pin))
        else $error("wave pin did not toggle");
    chk_wave_set: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl.wave_out_enable && !ctrl.wave_toggle_select && zero_ev
        && !match_ev |=> wave_out_pin == $past(ctrl.wave_polarity))
        else $error("wave pin not set on zero match");
    chk_wave_reset: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl.wave_out_enable && !ctrl.wave_toggle_select && match_ev
        |=> wave_out_pin != $past(ctrl.wave_polarity))
        else $error("wave pin not reset on compare");
    chk_wrap_toggle: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl.wrap_out_toggle_select && zero_wrap
        |=> wrap_out_pin != $past(wrap_out_pin))
        else $error("wrap pin did not toggle");
    chk_wrap_set: assert property (@(posedge mclk) disable iff (!resetn)
        !ctrl.wrap_out_toggle_select && zero_wrap
        |=> wrap_out_pin && flags.wrap_flag ##1 wrap_out_pin)
        else $error("wrap pin or flag not set");
    chk_reload_keep: assert property (@(posedge mclk) disable iff (!resetn)
        ctrl.reload_enable && !wr_rlc |=> $stable(reload_capture_reg))
        else $error("reload value changed by capture");
    chk_a_restart: assert property (@(posedge mclk) disable iff (!resetn)
        reload_a |=> counter_value == $past(reload_capture_reg)
        && flags.input_a_flag)
        else $error("input A restart failed");
    chk_a_overrun: assert property (@(posedge mclk) disable iff (!resetn)
        a_edge && flags.input_a_flag |=> flags.input_a_overrun)
        else $error("input A overrun not flagged");
    chk_b_capture: assert property (@(posedge mclk) disable iff (!resetn)
        b_edge && b_free |=> capture_reg == $past(counter_value)
        && flags.input_b_flag)
        else $error("input B capture wrong");
    chk_b_locked: assert property (@(posedge mclk) disable iff (!resetn)
        b_edge && !b_free |=> $stable(capture_reg))
        else $error("capture taken while flags set");
    chk_irq_terms: assert property (@(posedge mclk) disable iff (!resetn)
        ##1 irq == $past(|({flags.zero_match_flag, flags.match_flag,
        flags.wrap_flag, flags.input_b_flag, flags.input_a_flag} & irq_en)))
        else $error("interrupt does not follow flags");
    chk_hold_zero: assert property (@(posedge mclk) disable iff (!resetn)
        !run |=> counter_value == ZERO_COUNT)
        else $error("counter not cleared while stopped");
endmodule
`default_nettype wire

//--- verif/pulse_source.sv
// Behavioural model of an external pulse source on one capture input.
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    input wire logic mclk,  // Bench clock, paces the pulse only.
    input wire logic fire,  // One-cycle request for one pulse.
    input wire logic slow,  // High adds a long lead-in before the pulse.
    output logic pin        // Pulse output, idles low between pulses.
);
    logic [3:0] left = 4'h0;

    // Countdown to the pulse; a slow request delays the edges by six cycles.
    always @(posedge mclk) begin
        if (fire) begin
            left <= slow ? 4'hc : 4'h6;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end

    // Four cycles high so that the three-stage synchroniser cannot miss it.
    assign pin = (left != 4'h0) && (left < 4'h5);
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the auto-reload timer: bus, captures and pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import autoreload_timer_pkg::*;
;
    logic mclk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, slow = 1'b0, fire_a = 1'b0, fire_b = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q, v, c, prdata;
    logic pready, pslverr, slv, input_a, input_b;
    logic wave_out_pin, wrap_out_pin, irq;
    int errors = 0;
    int n_tests = 0;
    logic [11:0] cfg [7] = '{12'h0a9, 12'h029, 12'h069, 12'h089, 12'h009,
        12'h31d, 12'h30d};
    logic [31:0] want [7] = '{32'h40, 32'hc0, 32'h80, 32'h100, 32'h0,
        32'h80, 32'h100};
    // Expected interrupt per enable bit: a, b, match and zero set, wrap clear.
    logic [4:0] irq_want = 5'h1b;

    autoreload_timer_wave_capture autoreload_timer_wave_capture_i (
        .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .input_a(input_a),
        .input_b(input_b), .wave_out_pin(wave_out_pin),
        .wrap_out_pin(wrap_out_pin), .irq(irq));
    pulse_source src_a (.mclk(mclk), .fire(fire_a), .slow(slow),
        .pin(input_a));
    pulse_source src_b (.mclk(mclk), .fire(fire_b), .slow(slow),
        .pin(input_b));

    // Free-running 125 MHz clock.
    initial begin
        forever #4 mclk = ~mclk;
    end

    // Verdict and the single end of the run.
    task automatic end_sim();
        if (errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Compare tasks: exact value, inclusive range and changed value.
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_in(input string nm, input logic [31:0] lo, hi, g);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            errors++;
            $display("BAD %s expected %h..%h seen %h", nm, lo, hi, g);
        end
    endtask
    task automatic chk_ne(input string nm, input logic [31:0] old, g);
        n_tests++;
        if ((g != old) !== 1'b1) begin
            errors++;
            $display("BAD %s expected not %h seen %h", nm, old, g);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            errors++;
            end_sim();
        end
        @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Ask the sources for pulses; prompt and slow requests alternate.
    task automatic pulse(input logic [1:0] m);
        fire_a <= m[0];
        fire_b <= m[1];
        slow <= ~slow;
        @(posedge mclk);
        fire_a <= 1'b0;
        fire_b <= 1'b0;
        repeat (24) @(posedge mclk);
    endtask

    // High cycles of one pin over 256 cycles, i.e. whole pin periods.
    task automatic count_pin(input logic w, output logic [31:0] n);
        n = 32'h0;
        repeat (256) begin
            @(posedge mclk);
            n = n + {31'h0, w ? wrap_out_pin : wave_out_pin};
        end
    endtask

    task automatic do_reset();
        resetn <= 1'b0;
        repeat (5) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
    endtask

    // Main sequence: each block sets a mode and checks its outcome.
    initial begin
        do_reset();
        rd(OFS_MASK);
        chk("mask", 32'h0000ffff, q);
        wr(OFS_FLAGS, 32'h7f);
        rd(OFS_FLAGS);
        chk("flags", 32'h0, q);
        rd(OFS_COUNTER);
        chk("count", 32'h0, q);
        rd(8'h20);
        chk("slverr", 32'h1, {31'h0, slv});
        // Free-running captures on both inputs, rising edges.
        wr(OFS_CTRL, 32'hc09);
        pulse(2'b01);
        rd(OFS_FLAGS);
        chk("a_flag", 32'h1, q & 32'h3);
        rd(OFS_RELOAD_CAPTURE);
        v = q;
        wr(OFS_RELOAD_CAPTURE, 32'h1234);
        pulse(2'b01);
        rd(OFS_FLAGS);
        chk("a_over", 32'h3, q & 32'h3);
        rd(OFS_RELOAD_CAPTURE);
        chk("a_hold", v, q);
        pulse(2'b10);
        rd(OFS_FLAGS);
        chk("b_flag", 32'h4, q & 32'hc);
        rd(OFS_CAPTURE);
        v = q;
        pulse(2'b10);
        rd(OFS_FLAGS);
        chk("b_over", 32'hc, q & 32'hc);
        wr(OFS_FLAGS, 32'h7b);
        pulse(2'b10);
        rd(OFS_CAPTURE);
        chk("b_hold", v, q);
        wr(OFS_FLAGS, 32'h73);
        pulse(2'b10);
        rd(OFS_CAPTURE);
        chk_ne("b_new", v, q);
        // Restart from input B, falling edges selected.
        do_reset();
        wr(OFS_CTRL, 32'h20d);
        wr(OFS_RELOAD_CAPTURE, 32'h100);
        pulse(2'b10);
        rd(OFS_CAPTURE);
        chk("b_zero", 32'h0, q);
        rd(OFS_COUNTER);
        chk_in("b_start", 32'hd0, 32'hfc, q);
        pulse(2'b01);
        rd(OFS_FLAGS);
        chk("a_only", 32'h1, q & 32'h3);
        rd(OFS_RELOAD_CAPTURE);
        chk("rl_keep", 32'h100, q);
        pulse(2'b10);
        rd(OFS_CAPTURE);
        chk("b_nocap", 32'h0, q);
        rd(OFS_COUNTER);
        chk_in("b_restart", 32'hd0, 32'hfc, q);
        // Restart from input A; then A and B together.
        do_reset();
        wr(OFS_CTRL, 32'hd0d);
        wr(OFS_RELOAD_CAPTURE, 32'h100);
        wr(OFS_MASK, 32'hf);
        rd(OFS_COUNTER);
        chk("a_wait", 32'h0, q);
        pulse(2'b01);
        rd(OFS_COUNTER);
        chk_in("a_start", 32'hd0, 32'hfc, q);
        pulse(2'b01);
        rd(OFS_FLAGS);
        chk("a_over2", 32'h3, q & 32'h3);
        pulse(2'b11);
        rd(OFS_CAPTURE);
        chk_in("both_cap", 32'h80, 32'hf8, q);
        rd(OFS_COUNTER);
        chk_in("both_rl", 32'hd0, 32'hfc, q);
        // Interrupt terms with the counter stopped so flags stay put.
        wr(OFS_CTRL, 32'h004);
        chk("irq_off", 32'h0, {31'h0, irq});
        rd(OFS_FLAGS);
        chk("flags_held", 32'h67, q);
        for (int i = 0; i < 5; i++) begin
            wr(OFS_IRQ_EN, 32'h1 << i);
            rd(OFS_FLAGS);
            chk("irq", {31'h0, irq_want[i]}, {31'h0, irq});
        end
        wr(OFS_FLAGS, 32'h7e);
        wr(OFS_IRQ_EN, 32'h1);
        repeat (2) @(posedge mclk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        // Pin duty over whole periods, mask 000f and compare 000c.
        wr(OFS_RELOAD_CAPTURE, 32'h7);
        wr(OFS_COMPARE, 32'hc);
        for (int i = 0; i < 7; i++) begin
            // Stop first, so the short reload period starts from zero.
            if (i == 5) begin
                wr(OFS_CTRL, 32'h004);
            end
            wr(OFS_CTRL, {20'h0, cfg[i]});
            repeat (40) @(posedge mclk);
            count_pin(i > 4, c);
            chk("pin_duty", want[i], c);
        end
        rd(OFS_FLAGS);
        chk("wrap_flag", 32'h10, q & 32'h10);
        wr(OFS_CTRL, 32'h305);
        wr(OFS_FLAGS, 32'h6f);
        repeat (3) @(posedge mclk);
        chk("wrap_pin", 32'h0, {31'h0, wrap_out_pin});
        // Software restart at two prescaler ratios.
        wr(OFS_RELOAD_CAPTURE, 32'h100);
        wr(OFS_CTRL, 32'h00d);
        repeat (10) @(posedge mclk);
        rd(OFS_COUNTER);
        chk_in("sw_start", 32'he0, 32'hfa, q);
        wr(OFS_CTRL, 32'h004);
        rd(OFS_COUNTER);
        chk("stopped", 32'h0, q);
        wr(OFS_CTRL, 32'h00f);
        repeat (10) @(posedge mclk);
        rd(OFS_COUNTER);
        chk_in("div16", 32'hfd, 32'h100, q);
        end_sim();
    end
endmodule
`default_nettype wire
